// [shared/mpm_pkg.sv]
/*
 * constants and carriers of the serial management master:
 * register map, field positions, frame layout, clock limits.
 * assumes a 20 MHz peripheral clock and a 32-bit word-aligned register bus.
 */
package mpm_pkg;
	localparam int CLK_HZ      = 20_000_000;
	localparam int MGMT_MAX_HZ = 2_500_000;
	localparam int MGMT_TYP_HZ = 1_000_000;
	// least half period of the management clock, rounded up
	localparam logic [7:0] HALF_MIN  = 8'((CLK_HZ + 2 * MGMT_MAX_HZ - 1) / (2 * MGMT_MAX_HZ));
	localparam logic [7:0] DIV_RESET = 8'(CLK_HZ / (2 * MGMT_TYP_HZ));

	localparam logic [7:0] REG_CONTROL   = 8'h00;
	localparam logic [7:0] REG_RESPONDED = 8'h04;
	localparam logic [7:0] REG_CARRIER   = 8'h08;
	localparam logic [7:0] REG_CC_RAW    = 8'h0c;
	localparam logic [7:0] REG_CC_MASKED = 8'h10;
	localparam logic [7:0] REG_AD_RAW    = 8'h14;
	localparam logic [7:0] REG_AD_MASKED = 8'h18;
	localparam logic [7:0] REG_MASK_SET  = 8'h1c;
	localparam logic [7:0] REG_MASK_CLR  = 8'h20;
	localparam logic [7:0] REG_SLOT0     = 8'h24;
	localparam logic [7:0] REG_SLOT1     = 8'h28;
	localparam logic [7:0] REG_MON0      = 8'h2c;
	localparam logic [7:0] REG_MON1      = 8'h30;

	localparam int CTRL_ENABLE   = 0;
	localparam int CTRL_PREAMBLE = 1;
	localparam int CTRL_DIV_LSB  = 8;
	localparam int SLOT_KICK     = 31;
	localparam int SLOT_WRITE    = 30;
	localparam int SLOT_ACK      = 29;
	localparam int SLOT_REG_LSB  = 21;
	localparam int SLOT_PHY_LSB  = 16;
	localparam int MON_IRQ_EN    = 6;

	localparam logic [4:0] STATUS_REG = 5'h01;
	localparam int         LINK_BIT   = 2;
	localparam logic [1:0] FR_START   = 2'h1;
	localparam logic [1:0] OP_READ    = 2'h2;
	localparam logic [1:0] OP_WRITE   = 2'h1;
	localparam logic [1:0] TA_WRITE   = 2'h2;
	localparam logic [5:0] BIT_NOPRE  = 6'h20;
	localparam logic [5:0] BIT_TA     = 6'h2e;
	localparam logic [5:0] BIT_ACK    = 6'h2f;
	localparam logic [5:0] BIT_DATA   = 6'h30;
	localparam logic [5:0] BIT_LAST   = 6'h3f;

	typedef enum logic [0:0] {
		PH_IDLE = 1'b0,
		PH_RUN  = 1'b1
	} mpm_phase_e;

	typedef struct packed {
		logic        kick;
		logic        wr;
		logic        ack;
		logic [4:0]  targetRegIndex;
		logic [4:0]  targetPhyIndex;
		logic [15:0] data;
	} mpm_slot_s;

	typedef struct packed {
		logic       linkChangeIrqEnable;
		logic [4:0] monitoredPhyIndex;
	} mpm_mon_s;
endpackage

// [sim/mpm_phy_model.sv]
/*
 * model of the phys on the management bus: answers reads, stores writes.
 * assumes the master samples read data at clock rise, so data changes at fall.
 */
module mpm_phy_model (
	input  wire logic        mdc,     // management clock
	input  wire logic        oe,      // master drive enable
	input  wire logic        dout,    // master drive value
	input  wire logic [31:0] present, // populated addresses
	input  wire logic [31:0] link,    // addresses with link
	output logic             phyOe,   // model drive enable
	output logic             phyOut,  // model drive value
	output int               preLen   // ones before last start bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] hdr;
	logic [15:0] rdv;
	logic [15:0] wrv;
	logic [15:0] store [32];
	int          n = 0;
	int          ones = 0;
	int          preSeen = 0;
	logic        drvOe = 1'b0;
	logic        drvOut = 1'b0;
	assign preLen = preSeen;
	assign phyOe  = drvOe;
	assign phyOut = drvOut;
	// header after start: one, op, phy, reg
	always @(posedge mdc) begin
		if (n == 0) begin
			if (oe && dout) ones++;
			else if (oe) begin
				preSeen = ones;
				ones = 0;
				n = 1;
			end
		end else begin
			n++;
			if (n <= 14) hdr = {hdr[11:0], dout};
			else if (n >= 17 && hdr[11:10] == 2'h1) wrv = {wrv[14:0], dout};
			if (n == 32) begin
				if (hdr[11:10] == 2'h1 && present[hdr[9:5]]) store[hdr[4:0]] = wrv;
				n = 0;
			end
		end
	end
	// released wire floats to the pull-up level
	always @(negedge mdc) begin
		if (n == 15 && hdr[11:10] == 2'h2 && present[hdr[9:5]]) begin
			rdv = (hdr[4:0] == 5'h01) ? {13'h0, link[hdr[9:5]], 2'h0} : store[hdr[4:0]];
			drvOe = 1'b1;
			drvOut = 1'b0;
		end else if (drvOe && n >= 16 && n < 32) begin
			drvOut = rdv[15];
			rdv = {rdv[14:0], 1'b1};
		end else drvOe = 1'b0;
	end
endmodule // mpm_phy_model

// [sim/tb_top.sv]
/*
 * self-checking bench of the management master: avalon register bus, phy model.
 * assumes the data wire has a pull-up and registers as in the package map.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, avs_read, avs_write, mgmtClockPin, mgmtDataOut, mgmtDataOe;
	logic        carrierChangeIrq, accessDoneIrq, phyOe, phyOut, mgmtDataIn, avs_waitrequest;
	logic        lastMdc = 1'b0;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, present, link, q;
	logic [4:0]  p0, p1, pa;
	logic [15:0] d;
	int          fails = 0;
	int          check_count = 0;
	int          mdcRises = 0;
	int          sinceRise = 0;
	int          period = 0;
	int          preLen;

	assign mgmtDataIn = mgmtDataOe ? mgmtDataOut : (phyOe ? phyOut : 1'b1);

	mpm_top mpm_top_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mgmtClockPin(mgmtClockPin), .mgmtDataIn(mgmtDataIn), .mgmtDataOut(mgmtDataOut),
		.mgmtDataOe(mgmtDataOe), .carrierChangeIrq(carrierChangeIrq),
		.accessDoneIrq(accessDoneIrq));
	mpm_phy_model mpm_phy_model_i (.mdc(mgmtClockPin), .oe(mgmtDataOe), .dout(mgmtDataOut),
		.present(present), .link(link), .phyOe(phyOe), .phyOut(phyOut), .preLen(preLen));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// watch the management clock away from the launching edge
	always @(negedge clk) begin
		sinceRise++;
		if (mgmtClockPin && !lastMdc) begin
			mdcRises++;
			period = sinceRise;
			sinceRise = 0;
		end
		lastMdc = mgmtClockPin;
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			fails++;
			$display("MISMATCH at %0t: no bus answer", $time);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic waitKick(input logic [7:0] a);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0);
			n++;
		end while (q[31] !== 1'b0 && n < 2000);
		chk(32'(q[31]), 32'h0);
	endtask
	function automatic logic [31:0] slot(logic k, logic w, logic a, logic [4:0] ph,
		logic [15:0] dt);
		return {k, w, a, 3'h0, 5'h05, ph, dt};
	endfunction
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		$display("MISMATCH at %0t: watchdog expired", $time);
		fails++;
		test_done;
	end

	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		q = $urandom(70610);
		p0 = 5'($urandom);
		p1 = p0 ^ 5'h01;
		pa = p0 ^ 5'h02;
		present = ($urandom | (32'h1 << p0) | (32'h1 << p1)) & ~(32'h1 << pa);
		link = ($urandom | (32'h1 << p0)) & ~(32'h1 << p1);
		d = 16'($urandom);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(mpm_pkg::REG_CONTROL, 32'h0000_0a02);
		rdchk(8'hfc, 32'h0);
		repeat (100) @(posedge clk);
		chk(32'(mdcRises), 32'h0);
		bus(1'b1, mpm_pkg::REG_MON0, 32'h40 | 32'(p0));
		bus(1'b1, mpm_pkg::REG_MON1, 32'h40 | 32'(p1));
		bus(1'b1, mpm_pkg::REG_CONTROL, 32'h0000_0103);
		repeat (1000) @(posedge clk);
		chk(32'(period), 32'd8);
		chk(32'(preLen), 32'd32);
		repeat (18000) @(posedge clk);
		rdchk(mpm_pkg::REG_RESPONDED, present);
		rdchk(mpm_pkg::REG_CARRIER, present & link);
		rdchk(mpm_pkg::REG_CC_RAW, 32'h1);
		rdchk(mpm_pkg::REG_CC_MASKED, 32'h1);
		chk(32'(carrierChangeIrq), 32'h1);
		bus(1'b1, mpm_pkg::REG_CC_MASKED, 32'h1);
		bus(1'b1, mpm_pkg::REG_CC_RAW, 32'h1);
		rdchk(mpm_pkg::REG_CC_MASKED, 32'h0);
		@(negedge clk);
		chk(32'(carrierChangeIrq), 32'h0);
		bus(1'b1, mpm_pkg::REG_SLOT0, slot(1'b1, 1'b1, 1'b0, p0, d));
		waitKick(mpm_pkg::REG_SLOT0);
		rdchk(mpm_pkg::REG_AD_RAW, 32'h1);
		rdchk(mpm_pkg::REG_AD_MASKED, 32'h0);
		bus(1'b1, mpm_pkg::REG_AD_RAW, 32'h1);
		bus(1'b1, mpm_pkg::REG_MASK_SET, 32'h3);
		rdchk(mpm_pkg::REG_MASK_CLR, 32'h3);
		bus(1'b1, mpm_pkg::REG_SLOT0, slot(1'b1, 1'b0, 1'b0, p0, 16'h0));
		bus(1'b1, mpm_pkg::REG_SLOT1, slot(1'b1, 1'b0, 1'b0, pa, 16'h0));
		waitKick(mpm_pkg::REG_SLOT0);
		waitKick(mpm_pkg::REG_SLOT1);
		rdchk(mpm_pkg::REG_SLOT0, slot(1'b0, 1'b0, 1'b1, p0, d));
		bus(1'b0, mpm_pkg::REG_SLOT1, 32'h0);
		chk(32'(q[31:29]), 32'h0);
		rdchk(mpm_pkg::REG_AD_MASKED, 32'h3);
		@(negedge clk);
		chk(32'(accessDoneIrq), 32'h1);
		bus(1'b1, mpm_pkg::REG_AD_MASKED, 32'h1);
		rdchk(mpm_pkg::REG_AD_MASKED, 32'h2);
		bus(1'b1, mpm_pkg::REG_AD_MASKED, 32'h2);
		rdchk(mpm_pkg::REG_AD_MASKED, 32'h0);
		@(negedge clk);
		chk(32'(accessDoneIrq), 32'h0);
		bus(1'b1, mpm_pkg::REG_MASK_CLR, 32'h1);
		rdchk(mpm_pkg::REG_MASK_SET, 32'h2);
		link = link & ~(32'h1 << p0);
		repeat (18000) @(posedge clk);
		rdchk(mpm_pkg::REG_CC_RAW, 32'h1);
		rdchk(mpm_pkg::REG_CC_MASKED, 32'h1);
		bus(1'b1, mpm_pkg::REG_CONTROL, 32'h0000_0101);
		repeat (1200) @(posedge clk);
		chk(32'(preLen), 32'h0);
		test_done;
	end
endmodule // tb_top

// [src/mpm_top.sv]
/*
 * serial management master: background poll of all 32 addresses, two
 * monitored phys, two queued user access slots, avalon-mm register slave.
 * assumes a pull-up on the data wire and the 20 MHz clock as peripheral clock.
 */
// Function
// (RULE1) poll status register of all 32 addresses continuously while enabled
// (RULE2) management clock is clk divided by twice the programmed divisor, never over 2.5 MHz
// (RULE3) idle with no bus activity until the enable bit is set
// (RULE4) preamble sent by default, left out when the preamble bit is cleared
// (RULE5) set responded bit of polled address when the phy answered
// (RULE6) carrier bit set only if phy answered and reports link
// (RULE7) user reads also update the responded vector
// (RULE8) two monitored phys chosen by their monitor select registers
// (RULE9) monitored link change with enable sets raw and masked flags
// (RULE10) two user slots, served one at a time in round-robin order
// (RULE11) kickoff while enabled runs the slot's read or write autonomously
// (RULE12) finished slot clears kickoff and sets raw access-done bit
// (RULE13) masked access-done bit set only when slot's mask is enabled
// (RULE14) any masked access-done bit raises the completion interrupt
// (RULE15) software waits for kickoff clear before reloading a slot
// (RULE16) slot acknowledge bit tells whether the phy answered
// (RULE17) software sets divisor and preamble, enables, then waits before reading
// (RULE18) software writes all slot fields at once, polls kickoff for zero
// (RULE19) frames follow the standard two-wire serial management format
// (RULE20) after a read the ack bit and returned data stand in the slot
// (RULE21) carrier-change masked flag cleared by writing one
// (RULE22) access-done masked flag cleared by writing one
// (RULE23) phy answered when data low in the turnaround's second bit
// (RULE24) user frames go between poll frames, waiting at most one poll
// (RULE25) link change is new link state differing from the recorded one
module mpm_top (
	input  wire logic        clk,              // 20 MHz peripheral clock
	input  wire logic        rst_n,            // async reset, active low
	input  wire logic [7:0]  avs_address,      // byte address
	input  wire logic        avs_read,         // read request
	input  wire logic        avs_write,        // write request
	input  wire logic [31:0] avs_writedata,    // write data
	output logic      [31:0] avs_readdata,     // read data
	output logic             avs_waitrequest,  // stall
	output logic             mgmtClockPin,     // management clock out
	input  wire logic        mgmtDataIn,       // data wire level
	output logic             mgmtDataOut,      // data wire drive value
	output logic             mgmtDataOe,       // data wire drive enable
	output logic             carrierChangeIrq, // link change interrupt
	output logic             accessDoneIrq     // user access done interrupt
);
	typedef struct packed {
		logic                   sync1;
		logic                   sync2;
		logic                   waitReq;
		logic [31:0]            rdata;
		logic                   enable;
		logic                   preamble;
		logic [7:0]             divisor;
		logic [31:0]            responded;
		logic [31:0]            carrier;
		logic [1:0]             ccRaw;
		logic [1:0]             ccMasked;
		logic [1:0]             adRaw;
		logic [1:0]             adMasked;
		logic [1:0]             adMask;
		mpm_pkg::mpm_slot_s [1:0] slot;
		mpm_pkg::mpm_mon_s  [1:0] mon;
		logic [1:0]             monLink;
		mpm_pkg::mpm_phase_e    phase;
		logic [7:0]             divCnt;
		logic                   mdc;
		logic                   dOut;
		logic                   dOe;
		logic [5:0]             bitIdx;
		logic                   jobUser;
		logic                   jobSlot;
		logic                   jobRead;
		logic [4:0]             jobPhy;
		logic [4:0]             jobReg;
		logic [15:0]            jobData;
		logic                   rxAck;
		logic [15:0]            rxData;
		logic [4:0]             pollAddr;
		logic                   rrLast;
		logic                   lastWasUser;
		logic                   ccIrq;
		logic                   adIrq;
	} mpm_state_s;

	mpm_state_s s;
	mpm_state_s next_s;
	logic       busReq;
	logic       busWr;
	logic       frameEnd;
	logic [7:0] halfCnt;

	function automatic mpm_pkg::mpm_slot_s loadSlot(input logic [31:0] wd, input logic en);
		mpm_pkg::mpm_slot_s r;
		r.kick           = wd[mpm_pkg::SLOT_KICK] & en;
		r.wr             = wd[mpm_pkg::SLOT_WRITE];
		r.ack            = 1'b0;
		r.targetRegIndex = wd[mpm_pkg::SLOT_REG_LSB +: 5];
		r.targetPhyIndex = wd[mpm_pkg::SLOT_PHY_LSB +: 5];
		r.data           = wd[15:0];
		return r;
	endfunction

	function automatic mpm_pkg::mpm_mon_s loadMon(input logic [31:0] wd);
		mpm_pkg::mpm_mon_s r;
		r.linkChangeIrqEnable = wd[mpm_pkg::MON_IRQ_EN];
		r.monitoredPhyIndex   = wd[4:0];
		return r;
	endfunction

	function automatic logic [31:0] slotWord(input mpm_pkg::mpm_slot_s sl);
		logic [31:0] w;
		w                             = '0;
		w[mpm_pkg::SLOT_KICK]         = sl.kick;
		w[mpm_pkg::SLOT_WRITE]        = sl.wr;
		w[mpm_pkg::SLOT_ACK]          = sl.ack;
		w[mpm_pkg::SLOT_REG_LSB +: 5] = sl.targetRegIndex;
		w[mpm_pkg::SLOT_PHY_LSB +: 5] = sl.targetPhyIndex;
		w[15:0]                       = sl.data;
		return w;
	endfunction

	function automatic logic [31:0] monWord(input mpm_pkg::mpm_mon_s m);
		logic [31:0] w;
		w                       = '0;
		w[mpm_pkg::MON_IRQ_EN]  = m.linkChangeIrqEnable;
		w[4:0]                  = m.monitoredPhyIndex;
		return w;
	endfunction

	// frame bit at index i, msb first, preamble in bits 0..31
	function automatic logic frameBit(input logic rd, input logic [4:0] phy,
			input logic [4:0] rg, input logic [15:0] d, input logic [5:0] i);
		logic [63:0] f;
		f = {32'hffffffff, mpm_pkg::FR_START, rd ? mpm_pkg::OP_READ : mpm_pkg::OP_WRITE,
			phy, rg, mpm_pkg::TA_WRITE, d};
		return f[6'h3f - i];
	endfunction

	assign busReq   = avs_read | avs_write;
	assign busWr    = avs_write & ~s.waitReq;
	assign halfCnt  = (s.divisor < mpm_pkg::HALF_MIN) ? mpm_pkg::HALF_MIN : s.divisor; // RULE2
	assign frameEnd = s.enable && s.phase == mpm_pkg::PH_RUN && s.divCnt == 8'h00
		&& s.mdc && s.bitIdx == mpm_pkg::BIT_LAST;

	always_comb begin
		logic link;
		logic pick;
		link   = 1'b0;
		pick   = 1'b0;
		next_s = s;
		next_s.sync1 = mgmtDataIn;
		next_s.sync2 = s.sync1;

		// one-cycle answer: waitrequest drops for exactly one cycle
		next_s.waitReq = !(busReq && s.waitReq);
		if (busReq && s.waitReq) begin
			case (avs_address)
				mpm_pkg::REG_CONTROL: begin
					next_s.rdata = '0;
					next_s.rdata[mpm_pkg::CTRL_ENABLE] = s.enable;
					next_s.rdata[mpm_pkg::CTRL_PREAMBLE] = s.preamble;
					next_s.rdata[mpm_pkg::CTRL_DIV_LSB +: 8] = s.divisor;
				end
				mpm_pkg::REG_RESPONDED: next_s.rdata = s.responded;
				mpm_pkg::REG_CARRIER:   next_s.rdata = s.carrier;
				mpm_pkg::REG_CC_RAW:    next_s.rdata = {30'h0, s.ccRaw};
				mpm_pkg::REG_CC_MASKED: next_s.rdata = {30'h0, s.ccMasked};
				mpm_pkg::REG_AD_RAW:    next_s.rdata = {30'h0, s.adRaw};
				mpm_pkg::REG_AD_MASKED: next_s.rdata = {30'h0, s.adMasked};
				mpm_pkg::REG_MASK_SET:  next_s.rdata = {30'h0, s.adMask};
				mpm_pkg::REG_MASK_CLR:  next_s.rdata = {30'h0, s.adMask};
				mpm_pkg::REG_SLOT0:     next_s.rdata = slotWord(s.slot[0]);
				mpm_pkg::REG_SLOT1:     next_s.rdata = slotWord(s.slot[1]);
				mpm_pkg::REG_MON0:      next_s.rdata = monWord(s.mon[0]);
				mpm_pkg::REG_MON1:      next_s.rdata = monWord(s.mon[1]);
				default:                next_s.rdata = '0;
			endcase
		end

		// software writes first, so hardware sets below win
		if (busWr) begin
			case (avs_address)
				mpm_pkg::REG_CONTROL: begin
					next_s.enable   = avs_writedata[mpm_pkg::CTRL_ENABLE]; // RULE3
					next_s.preamble = avs_writedata[mpm_pkg::CTRL_PREAMBLE];
					next_s.divisor  = avs_writedata[mpm_pkg::CTRL_DIV_LSB +: 8];
				end
				mpm_pkg::REG_CC_RAW:    next_s.ccRaw = s.ccRaw & ~avs_writedata[1:0];
				mpm_pkg::REG_CC_MASKED: next_s.ccMasked = s.ccMasked & ~avs_writedata[1:0]; // RULE21
				mpm_pkg::REG_AD_RAW:    next_s.adRaw = s.adRaw & ~avs_writedata[1:0];
				mpm_pkg::REG_AD_MASKED: next_s.adMasked = s.adMasked & ~avs_writedata[1:0]; // RULE22
				mpm_pkg::REG_MASK_SET:  next_s.adMask = s.adMask | avs_writedata[1:0];
				mpm_pkg::REG_MASK_CLR:  next_s.adMask = s.adMask & ~avs_writedata[1:0];
				mpm_pkg::REG_SLOT0: begin
					if (!s.slot[0].kick) next_s.slot[0] = loadSlot(avs_writedata, s.enable); // RULE11
				end
				mpm_pkg::REG_SLOT1: begin
					if (!s.slot[1].kick) next_s.slot[1] = loadSlot(avs_writedata, s.enable); // RULE11
				end
				mpm_pkg::REG_MON0:      next_s.mon[0] = loadMon(avs_writedata); // RULE8
				mpm_pkg::REG_MON1:      next_s.mon[1] = loadMon(avs_writedata); // RULE8
				default:                next_s.rdata = s.rdata;
			endcase
		end

		if (!s.enable) begin
			next_s.phase  = mpm_pkg::PH_IDLE; // RULE3
			next_s.mdc    = 1'b0;
			next_s.dOut   = 1'b0;
			next_s.dOe    = 1'b0;
			next_s.divCnt = '0;
		end else begin
			case (s.phase)
				mpm_pkg::PH_IDLE: begin
					// user job only right after a poll frame
					if ((s.slot[0].kick || s.slot[1].kick) && !s.lastWasUser) begin // RULE24
						pick = (s.slot[0].kick && s.slot[1].kick) ? !s.rrLast
							: s.slot[1].kick; // RULE10
						next_s.jobUser = 1'b1;
						next_s.jobSlot = pick;
						next_s.jobRead = !s.slot[pick].wr;
						next_s.jobPhy  = s.slot[pick].targetPhyIndex;
						next_s.jobReg  = s.slot[pick].targetRegIndex;
						next_s.jobData = s.slot[pick].data;
					end else begin
						next_s.jobUser = 1'b0; // RULE1
						next_s.jobRead = 1'b1;
						next_s.jobPhy  = s.pollAddr;
						next_s.jobReg  = mpm_pkg::STATUS_REG;
						next_s.jobData = '0;
					end
					next_s.phase  = mpm_pkg::PH_RUN;
					next_s.bitIdx = s.preamble ? 6'h00 : mpm_pkg::BIT_NOPRE; // RULE4
					next_s.divCnt = halfCnt - 8'h01;
					next_s.mdc    = 1'b0;
					next_s.rxAck  = 1'b0;
					next_s.dOe    = 1'b1;
					next_s.dOut   = frameBit(next_s.jobRead, next_s.jobPhy, next_s.jobReg,
						next_s.jobData, next_s.bitIdx); // RULE19
				end
				mpm_pkg::PH_RUN: begin
					if (s.divCnt != 8'h00) begin
						next_s.divCnt = s.divCnt - 8'h01;
					end else if (!s.mdc) begin
						next_s.divCnt = halfCnt - 8'h01;
						next_s.mdc    = 1'b1;
						if (s.jobRead && s.bitIdx == mpm_pkg::BIT_ACK)
							next_s.rxAck = !s.sync2; // RULE23
						if (s.jobRead && s.bitIdx >= mpm_pkg::BIT_DATA)
							next_s.rxData = {s.rxData[14:0], s.sync2};
					end else begin
						next_s.divCnt = halfCnt - 8'h01;
						next_s.mdc    = 1'b0;
						if (s.bitIdx == mpm_pkg::BIT_LAST) begin
							next_s.phase       = mpm_pkg::PH_IDLE;
							next_s.dOe         = 1'b0;
							next_s.lastWasUser = s.jobUser;
							if (s.jobRead)
								next_s.responded[s.jobPhy] = s.rxAck; // RULE5 RULE7
							if (!s.jobUser) begin
								link = s.rxAck & s.rxData[mpm_pkg::LINK_BIT];
								next_s.carrier[s.jobPhy] = link; // RULE6
								next_s.pollAddr = s.pollAddr + 5'h01; // RULE1
								for (int k = 0; k < 2; k++) begin
									if (s.mon[k].monitoredPhyIndex == s.jobPhy
										&& link != s.monLink[k]) begin // RULE25
										next_s.monLink[k] = link; // RULE8
										if (s.mon[k].linkChangeIrqEnable) begin
											next_s.ccRaw[k]    = 1'b1; // RULE9
											next_s.ccMasked[k] = 1'b1; // RULE9
										end
									end
								end
							end else begin
								next_s.slot[s.jobSlot].kick = 1'b0; // RULE12
								if (s.jobRead) begin
									next_s.slot[s.jobSlot].ack  = s.rxAck; // RULE16 RULE20
									next_s.slot[s.jobSlot].data = s.rxData; // RULE20
								end
								next_s.adRaw[s.jobSlot] = 1'b1; // RULE12
								if (s.adMask[s.jobSlot])
									next_s.adMasked[s.jobSlot] = 1'b1; // RULE13
								next_s.rrLast = s.jobSlot; // RULE10
							end
						end else begin
							next_s.bitIdx = s.bitIdx + 6'h01;
							next_s.dOe    = !s.jobRead || (s.bitIdx + 6'h01) < mpm_pkg::BIT_TA;
							next_s.dOut   = frameBit(s.jobRead, s.jobPhy, s.jobReg, s.jobData,
								s.bitIdx + 6'h01); // RULE19
						end
					end
				end
				default: next_s.phase = mpm_pkg::PH_IDLE;
			endcase
		end
		next_s.ccIrq = |next_s.ccMasked;
		next_s.adIrq = |next_s.adMasked; // RULE14
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s          <= '0;
			s.waitReq  <= 1'b1;
			s.preamble <= 1'b1;
			s.divisor  <= mpm_pkg::DIV_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata     = s.rdata;
	assign avs_waitrequest  = s.waitReq;
	assign mgmtClockPin     = s.mdc;
	assign mgmtDataOut      = s.dOut;
	assign mgmtDataOe       = s.dOe;
	assign carrierChangeIrq = s.ccIrq;
	assign accessDoneIrq    = s.adIrq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_idle_quiet: assert property (!s.enable |=> !mgmtClockPin && !mgmtDataOe) // RULE3
		else $error("bus active while disabled");
	a_high_half: assert property ($rose(mgmtClockPin) |-> mgmtClockPin [*4]) // RULE2
		else $error("management clock high half too short");
	a_low_half: assert property ($fell(mgmtClockPin) |-> !mgmtClockPin [*4]) // RULE2
		else $error("management clock low half too short");
	a_preamble_ones: assert property (s.phase == mpm_pkg::PH_RUN
		&& s.bitIdx < mpm_pkg::BIT_NOPRE |-> mgmtDataOut && mgmtDataOe) // RULE4
		else $error("preamble bit not driven high");
	a_poll_respond: assert property (frameEnd && !s.jobUser
		|=> s.responded[$past(s.jobPhy)] == $past(s.rxAck)) // RULE5
		else $error("responded bit does not follow answer");
	a_carrier_ack: assert property (frameEnd && !s.jobUser && !s.rxAck
		|=> !s.carrier[$past(s.jobPhy)]) // RULE6
		else $error("carrier set without answer");
	a_user_respond: assert property (frameEnd && s.jobUser && s.jobRead // RULE7
		|=> s.responded[$past(s.jobPhy)] == $past(s.rxAck))
		else $error("user read did not update responded bit");
	a_kick_done: assert property (frameEnd && s.jobUser
		|=> !s.slot[$past(s.jobSlot)].kick && s.adRaw[$past(s.jobSlot)]) // RULE12
		else $error("finished slot not cleared or flagged");
	a_done_irq: assert property (s.adMasked != 2'h0 |-> accessDoneIrq) // RULE14
		else $error("completion interrupt missing");
	a_round_robin: assert property (s.enable && s.phase == mpm_pkg::PH_IDLE
		&& !s.lastWasUser && s.slot[0].kick && s.slot[1].kick
		|=> s.jobUser && s.jobSlot != $past(s.rrLast)) // RULE10
		else $error("round robin order broken");
	a_user_waits: assert property (frameEnd && !s.jobUser && s.slot[0].kick
		&& s.enable |=> ##1 s.jobUser) // RULE24
		else $error("queued user access skipped");
endmodule // mpm_top
